// ---- core/fractional_pll_controller.v ----
// Purpose: Control logic of a fractional PLL: reference select, divider, gating, lock
// Assumes: Analog oscillator modelled by a lock input; reference and timer clocks sampled
// Notes:   Divided and selected reference is a pulse stream; ratio drives oscillator control
//          Reference output stays low while the loop is off
// Behaviour
// - Select reference from three sources only
// - Fast crystal divided by two times (div+1)
// - Output is reference times integer+1+frac/16
// - Fraction zero means integer mode
// - Enable bit starts and stops loop
// - Output clock reset while disabled
// - Nonzero lock time validates after timer
// - Lock timer counts 32 kHz clock
// - First edge released per fast/time mode
// - After first edge, gate on lock unless bypassed
// - Ratio write clears lock until settled
// - Lock falling edge sets lock-fail flag
// - Lock-fail cleared by writing one
// - Filter automatic unless software overrides
// - Phase detector bypass skips converter
// - Timeout interrupt when lock time elapses
`timescale 1ns/1ps
`include "fpll_ctrl_defs.vh"
module fractional_pll_controller #(
  parameter DIV_W   = 11,
  parameter INT_W   = 12,
  parameter LOCK_TIME_SELECT_W = 3
) (
  // Clock and reset
  input  wire              clk_sys_i,
  input  wire              rst_n_i,
  // Register port
  input  wire [3:0]        addr_i,
  input  wire [31:0]       wdata_i,
  input  wire              wr_i,
  input  wire              rd_i,
  output reg  [31:0]       rdata_o,
  // Reference oscillators and timer clock (asynchronous pins)
  input  wire              slow_crystal_oscillator_i,
  input  wire              fast_crystal_oscillator_i,
  input  wire              generic_reference_clock_i,
  input  wire              lock_timer_clock_i,
  // Oscillator core interface
  input  wire              core_lock_i,
  output reg               pll_reference_clock_o,
  output reg               core_enable_o,
  output reg  [INT_W-1:0]  ratio_integer_o,
  output reg  [3:0]        ratio_fraction_o,
  output reg               fractional_mode_o,
  output reg               filter_override_o,
  output reg  [1:0]        filter_select_o,
  output reg               phase_detector_bypass_o,
  output reg               output_clock_reset_o,
  output reg               output_clock_gater_o,
  // Interrupt
  output reg               irq_o
);

  // Control registers
  reg               enable;
  reg [1:0]         reference_select;
  reg [LOCK_TIME_SELECT_W-1:0] lock_time_select;
  reg               wake_up_fast;
  reg               lock_bypass;
  reg [DIV_W-1:0]   xtal_div;
  reg [1:0]         filter_sel;
  reg               filter_ovr;
  reg               pd_bypass;
  reg [INT_W-1:0]   ratio_integer;
  reg [3:0]         ratio_fraction;
  reg [2:0]         int_flag;
  reg [2:0]         int_mask;

  // Three-stage synchronisers, one per asynchronous input. A level counts only
  // once stages two and three agree, so a metastable sample never reaches the
  // edge detectors; the price is about four cycles of latency per input.
  localparam NUM_PINS = 5;
  wire [NUM_PINS-1:0] pin_raw;
  wire [NUM_PINS-1:0] pin_flt;
  assign pin_raw = {core_lock_i, lock_timer_clock_i, generic_reference_clock_i,
                    fast_crystal_oscillator_i, slow_crystal_oscillator_i};
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1) begin : g_sync
      reg [2:0] stage;
      reg       level;
      always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          stage <= 3'h0;
          level <= 1'b0;
        end else begin
          stage <= {stage[1:0], pin_raw[g]};
          if (stage[1] == stage[2]) begin
            level <= stage[2];
          end
        end
      end
      assign pin_flt[g] = level;
    end
  endgenerate

  // Filtered levels by name
  wire f_slow = pin_flt[0];
  wire f_fast = pin_flt[1];
  wire f_gen  = pin_flt[2];
  wire f_tmr  = pin_flt[3];
  wire f_lock = pin_flt[4];

  // Edge detect on filtered levels
  reg  fast_d, tmr_d;
  wire fast_rise = f_fast & ~fast_d;
  wire tick_32k  = f_tmr & ~tmr_d;

  // fast crystal divider: toggles every (div+1) rising edges, giving /(2*(div+1))
  // Counting rising edges only keeps the divided duty cycle at one half
  reg [DIV_W-1:0] div_cnt;
  reg             div_clk;
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      fast_d  <= 1'b0;
      tmr_d   <= 1'b0;
      div_cnt <= {DIV_W{1'b0}};
      div_clk <= 1'b0;
    end else begin
      fast_d <= f_fast;
      tmr_d  <= f_tmr;
      if (fast_rise) begin
        if (div_cnt == xtal_div) begin
          div_cnt <= {DIV_W{1'b0}};
          div_clk <= ~div_clk;
        end else begin
          div_cnt <= div_cnt + 1'b1;
        end
      end
    end
  end

  // reference mux, only three legal codes; others give no reference
  // Code three stays dark rather than aliasing a live source
  reg next_ref;
  always @* begin
    case (reference_select)
      `REF_SLOW_XTAL: next_ref = f_slow;
      `REF_FAST_XTAL: next_ref = div_clk;
      `REF_GENERIC:   next_ref = f_gen;
      default:        next_ref = 1'b0;
    endcase
  end

  // Start-up state machine
  localparam ST_OFF   = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_RUN   = 2'h2;
  reg [1:0]         state;
  reg [7:0]         start_cnt;
  reg [LOCK_TIME_SELECT_W-1:0] ltimer;
  reg               timer_done;
  reg [7:0]         settle_cnt;
  reg               lock;
  reg               lock_d;
  reg               first_edge;
  wire              ratio_wr = wr_i && (addr_i == `ADDR_RATIO);

  // lock indication: timer when lock time set, else core detection
  // In timer mode the core's own detector is ignored entirely
  wire lock_src = (lock_time_select != {LOCK_TIME_SELECT_W{1'b0}}) ? timer_done : f_lock;

  // Interrupt events, each a one-cycle pulse
  wire [2:0] flag_set;
  wire [2:0] flag_clr;
  // timeout pulses in the cycle the countdown first reads zero
  assign flag_set[`FLAG_LOCK_TIMEOUT] = !timer_done && (ltimer == {LOCK_TIME_SELECT_W{1'b0}})
                                        && (state != ST_OFF)
                                        && (lock_time_select != {LOCK_TIME_SELECT_W{1'b0}});
  // falling internal lock, the drop after a ratio update included
  assign flag_set[`FLAG_LOCK_FAIL]    = lock_d & ~lock;
  assign flag_set[`FLAG_LOCK]         = lock & ~lock_d;
  // only a written one clears a flag
  assign flag_clr = (wr_i && (addr_i == `ADDR_INT_FLAG)) ? wdata_i[2:0] : 3'h0;

  // Loop sequencing
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state      <= ST_OFF;
      start_cnt  <= 8'h00;
      ltimer     <= {LOCK_TIME_SELECT_W{1'b0}};
      timer_done <= 1'b0;
      settle_cnt <= 8'h00;
      lock       <= 1'b0;
      lock_d     <= 1'b0;
      first_edge <= 1'b0;
    end else begin
      lock_d <= lock;
      case (state)
        ST_OFF: begin
          // Lock state except the settle count cleared before each start
          first_edge <= 1'b0;
          lock       <= 1'b0;
          timer_done <= 1'b0;
          // enable starts; timer loads lock time
          if (enable) begin
            state     <= ST_START;
            start_cnt <= `STARTUP_CYCLES;
            ltimer    <= lock_time_select;
          end
        end
        ST_START, ST_RUN: begin
          if (start_cnt != 8'h00) begin
            start_cnt <= start_cnt - 8'h01;
          end
          // timer ticks on 32 kHz edges; countdown
          if (tick_32k && (ltimer != {LOCK_TIME_SELECT_W{1'b0}})) begin
            ltimer <= ltimer - 1'b1;
          end
          if ((ltimer == {LOCK_TIME_SELECT_W{1'b0}}) && (lock_time_select != {LOCK_TIME_SELECT_W{1'b0}})) begin
            timer_done <= 1'b1;
          end
          // ratio update drops lock until settled
          // Fixed settle time stands in for the core re-acquiring
          if (ratio_wr) begin
            settle_cnt <= `SETTLE_CYCLES;
            lock       <= 1'b0;
          end else if (settle_cnt != 8'h00) begin
            settle_cnt <= settle_cnt - 8'h01;
            lock       <= 1'b0;
          end else begin
            lock <= lock_src;
          end
          if (state == ST_START) begin
            if (wake_up_fast ? (start_cnt == 8'h00) : lock_src) begin
              state      <= ST_RUN;
              first_edge <= 1'b1;
            end
          end
          if (!enable) begin
            state <= ST_OFF;
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // Register writes and sticky flags
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      enable           <= 1'b0;
      reference_select <= 2'h0;
      lock_time_select <= {LOCK_TIME_SELECT_W{1'b0}};
      wake_up_fast     <= 1'b0;
      lock_bypass      <= 1'b0;
      xtal_div         <= {DIV_W{1'b0}};
      filter_sel       <= 2'h0;
      filter_ovr       <= 1'b0;
      pd_bypass        <= 1'b0;
      ratio_integer    <= {INT_W{1'b0}};
      ratio_fraction   <= 4'h0;
      int_flag         <= 3'h0;
      int_mask         <= 3'h0;
    end else begin
      if (wr_i) begin
        case (addr_i)
          `ADDR_CTRL_FIRST: enable <= wdata_i[1];
          `ADDR_CTRL_SECOND: begin
            filter_sel       <= wdata_i[1:0];
            filter_ovr       <= wdata_i[2];
            pd_bypass        <= wdata_i[3];
            wake_up_fast     <= wdata_i[4];
            reference_select <= wdata_i[6:5];
            lock_time_select <= wdata_i[10:8];
            lock_bypass      <= wdata_i[12];
            xtal_div         <= wdata_i[26:16];
          end
          `ADDR_RATIO: begin
            ratio_integer  <= wdata_i[INT_W-1:0];
            ratio_fraction <= wdata_i[19:16];
          end
          `ADDR_INT_MASK: int_mask <= wdata_i[2:0];
          default: ;
        endcase
      end
      // write-one clear; a same-cycle event wins over the clear
      int_flag <= (int_flag & ~flag_clr) | flag_set;
    end
  end

  // Read data and registered outputs
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_o                 <= 32'h0000_0000;
      pll_reference_clock_o   <= 1'b0;
      core_enable_o           <= 1'b0;
      ratio_integer_o         <= {INT_W{1'b0}};
      ratio_fraction_o        <= 4'h0;
      fractional_mode_o       <= 1'b0;
      filter_override_o       <= 1'b0;
      filter_select_o         <= 2'h0;
      phase_detector_bypass_o <= 1'b0;
      output_clock_reset_o    <= 1'b1;
      output_clock_gater_o    <= 1'b0;
      irq_o                   <= 1'b0;
    end else begin
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        case (addr_i)
          `ADDR_CTRL_FIRST:  rdata_o <= {30'h0, enable, 1'b0};
          `ADDR_CTRL_SECOND: rdata_o <= {5'h0, xtal_div, 3'h0, lock_bypass, 1'b0,
                                         lock_time_select, 1'b0, reference_select,
                                         wake_up_fast, pd_bypass, filter_ovr, filter_sel};
          `ADDR_RATIO:       rdata_o <= {12'h0, ratio_fraction, {(16-INT_W){1'b0}},
                                         ratio_integer};
          `ADDR_STATUS:      rdata_o <= {28'h0, first_edge, (state != ST_OFF), 1'b0, lock};
          `ADDR_INT_FLAG:    rdata_o <= {29'h0, int_flag};
          `ADDR_INT_MASK:    rdata_o <= {29'h0, int_mask};
          default:           rdata_o <= 32'h0000_0000;
        endcase
      end
      // Reference reaches the core only once out of off, never beside a held reset
      pll_reference_clock_o <= next_ref & (state != ST_OFF);
      core_enable_o         <= (state != ST_OFF);
      // ratio to oscillator; fraction nonzero selects fractional mode
      ratio_integer_o       <= ratio_integer;
      ratio_fraction_o      <= ratio_fraction;
      fractional_mode_o     <= (ratio_fraction != 4'h0);
      filter_override_o     <= filter_ovr;
      filter_select_o       <= filter_ovr ? filter_sel : 2'h0;
      phase_detector_bypass_o <= pd_bypass;
      // output clock held in reset when off
      output_clock_reset_o  <= (state == ST_OFF);
      output_clock_gater_o  <= (state == ST_RUN) && (lock_bypass || lock);
      irq_o                 <= |(int_flag & int_mask);
    end
  end

endmodule

// ---- core/fpll_ctrl_defs.vh ----
// Purpose: Register offsets, fields and reset values of the PLL controller
// Assumes: Word addressed plain register port
// Notes:   Definitions only
`ifndef FPLL_CTRL_DEFS_VH
`define FPLL_CTRL_DEFS_VH
`define ADDR_CTRL_FIRST   4'h0
`define ADDR_CTRL_SECOND  4'h1
`define ADDR_RATIO        4'h2
`define ADDR_STATUS       4'h3
`define ADDR_INT_FLAG     4'h4
`define ADDR_INT_MASK     4'h5
`define REF_SLOW_XTAL     2'h0
`define REF_FAST_XTAL     2'h1
`define REF_GENERIC       2'h2
`define RST_CTRL_SECOND   32'h0000_0000
`define RST_RATIO         32'h0000_0000
`define FLAG_LOCK         0
`define FLAG_LOCK_FAIL    1
`define FLAG_LOCK_TIMEOUT 2
`define SETTLE_CYCLES     8'h40
`define STARTUP_CYCLES    8'h10
`endif

// ---- tb/fpll_assertions.sv ----
// Purpose: Port level checks of the PLL controller
// Assumes: Registered outputs, tb keeps writes two cycles apart
// Notes:   Bound to every controller instance below
`timescale 1ns/1ps
`include "fpll_ctrl_defs.vh"
module fpll_assertions #(
  parameter INT_W = 12
) (
  // Clock, reset and register port
  input wire              clk_sys_i,
  input wire              rst_n_i,
  input wire [3:0]        addr_i,
  input wire [31:0]       wdata_i,
  input wire              wr_i,
  input wire              rd_i,
  input wire [31:0]       rdata_o,
  // Core side and interrupt
  input wire              pll_reference_clock_o,
  input wire              core_enable_o,
  input wire [INT_W-1:0]  ratio_integer_o,
  input wire [3:0]        ratio_fraction_o,
  input wire              fractional_mode_o,
  input wire              filter_override_o,
  input wire [1:0]        filter_select_o,
  input wire              output_clock_reset_o,
  input wire              output_clock_gater_o,
  input wire              irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Write to the enable register
  wire ctl_wr = wr_i && addr_i == `ADDR_CTRL_FIRST;
  // Loop state as seen at the pins
  off_reset_a: assert property (output_clock_reset_o != core_enable_o)
    else $error("reset and enable disagree");
  ref_off_a: assert property (output_clock_reset_o && $past(output_clock_reset_o)
    |-> !pll_reference_clock_o) else $error("reference while off");
  gater_run_a: assert property (output_clock_gater_o |-> core_enable_o)
    else $error("gater open while off");
  stop_loop_a: assert property (ctl_wr && !wdata_i[1] |-> ##[1:4] output_clock_reset_o)
    else $error("loop did not stop");
  start_loop_a: assert property (ctl_wr && wdata_i[1] && output_clock_reset_o
    |-> ##[1:4] core_enable_o) else $error("loop did not start");
  // Ratio and filter outputs; two cycles covers either copy depth
  ratio_copy_a: assert property (wr_i && addr_i == `ADDR_RATIO |-> ##2
    ratio_integer_o == $past(wdata_i[INT_W-1:0], 2) && ratio_fraction_o == $past(wdata_i[19:16], 2))
    else $error("ratio not copied");
  frac_mode_a: assert property (fractional_mode_o == (ratio_fraction_o != 4'h0))
    else $error("mode disagrees with fraction");
  filter_auto_a: assert property (!filter_override_o |-> filter_select_o == 2'h0)
    else $error("filter select without override");
  // Read data only in the cycle after a read
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data outside answer cycle");
  cover property (output_clock_gater_o);
  cover property (irq_o);
  cover property (fractional_mode_o);
endmodule

bind fractional_pll_controller fpll_assertions #(.INT_W(INT_W)) i_chk (.clk_sys_i, .rst_n_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pll_reference_clock_o, .core_enable_o,
  .ratio_integer_o, .ratio_fraction_o, .fractional_mode_o, .filter_override_o,
  .filter_select_o, .output_clock_reset_o, .output_clock_gater_o, .irq_o);

// ---- tb/ref_osc_model.sv ----
// Purpose: Reference oscillators, lock timer clock and analog lock
// Assumes: Rates scaled down so the synchronisers see every level
// Notes:   Lock rises 20 cycles after enable while the bench allows it
`timescale 1ns/1ps
module ref_osc_model (
  // Clock and control
  input  wire  clk_sys_i,
  input  wire  core_enable_i,
  input  wire  lock_allow_i,
  // Sources and lock
  output wire  slow_o,
  output wire  fast_o,
  output wire  generic_o,
  output wire  timer_o,
  output wire  core_lock_o
);
  reg [7:0] cnt      = 8'h00;
  reg [4:0] wait_cnt = 5'h00;
  assign slow_o      = cnt[3];
  assign fast_o      = cnt[2];
  assign generic_o   = cnt[4];
  assign timer_o     = cnt[5];
  assign core_lock_o = wait_cnt == 5'h14;
  // Off the sampling edge, so no race with the controller
  always @(negedge clk_sys_i) begin
    cnt <= cnt + 8'h01;
    if (!(core_enable_i && lock_allow_i))
      wait_cnt <= 5'h00;
    else if (!core_lock_o)
      wait_cnt <= wait_cnt + 5'h01;
  end
endmodule

// ---- tb/tb.sv ----
// Purpose: Self-checking bench of the PLL controller
// Assumes: Scaled source rates from the partner model
// Notes:   Expectations from field layout; edge counts allow one of slack
`timescale 1ns/1ps
`include "fpll_ctrl_defs.vh"
module tb;
  reg         clk_sys_i  = 1'b0;
  reg         rst_n_i    = 1'b0;
  reg  [3:0]  addr_i     = 4'h0;
  reg  [31:0] wdata_i    = 32'h0000_0000;
  reg         wr_i       = 1'b0;
  reg         rd_i       = 1'b0;
  reg         lock_allow = 1'b0;
  reg  [31:0] d;
  reg  [31:0] model_ratio = `RST_RATIO;
  wire [31:0] rdata_o;
  wire [11:0] ratio_integer_o;
  wire [3:0]  ratio_fraction_o;
  wire [1:0]  filter_select_o;
  wire [2:0]  srcs;
  wire        timer, core_lock, pll_reference_clock_o, core_enable_o, fractional_mode_o;
  wire        filter_override_o, phase_detector_bypass_o, output_clock_reset_o;
  wire        output_clock_gater_o, irq_o;
  integer     num_errors = 0, checked = 0, seed = 14356, i, r, k, ex;
  fractional_pll_controller i_fractional_pll_controller (.clk_sys_i, .rst_n_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .slow_crystal_oscillator_i(srcs[0]),
    .fast_crystal_oscillator_i(srcs[1]), .generic_reference_clock_i(srcs[2]),
    .lock_timer_clock_i(timer), .core_lock_i(core_lock), .pll_reference_clock_o,
    .core_enable_o, .ratio_integer_o, .ratio_fraction_o, .fractional_mode_o,
    .filter_override_o, .filter_select_o, .phase_detector_bypass_o,
    .output_clock_reset_o, .output_clock_gater_o, .irq_o);
  ref_osc_model i_ref_osc_model (.clk_sys_i, .core_enable_i(core_enable_o),
    .lock_allow_i(lock_allow), .slow_o(srcs[0]), .fast_o(srcs[1]), .generic_o(srcs[2]),
    .timer_o(timer), .core_lock_o(core_lock));
  // Clock
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  // Compare and count
  task cmp(input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (e !== g) begin
        num_errors = num_errors + 1;
        $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  // Bus write, one cycle strobe
  task wr(input [3:0] a, input [31:0] v);
    begin
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      // Model: unused ratio bits read back as zero
      if (a == `ADDR_RATIO) model_ratio = v & 32'h000F_0FFF;
    end
  endtask
  // Bus read, data taken in the answer cycle only
  task rdc(input [3:0] a, input [31:0] m, input [31:0] e);
    begin
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 cmp(e, rdata_o & m);
    end
  endtask
  // Rising edges of reference output and chosen source over 640 cycles
  task count(input integer s);
    reg p, q;
    begin
      r = 0;
      k = 0;
      p = 1'b0;
      q = 1'b0;
      repeat (640) begin
        @(posedge clk_sys_i);
        #2 if (pll_reference_clock_o && !p) r = r + 1;
        if (srcs[s] === 1'b1 && !q) k = k + 1;
        p = pll_reference_clock_o;
        q = srcs[s] === 1'b1;
      end
    end
  endtask
  task close_out;
    begin
      if (num_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // Hang guard, about two and a half times the expected run
  initial begin
    #200000;
    num_errors = num_errors + 1;
    close_out;
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rdc(`ADDR_RATIO, 32'hFFFF_FFFF, `RST_RATIO);
    rdc(`ADDR_CTRL_SECOND, 32'hFFFF_FFFF, `RST_CTRL_SECOND);
    wr(4'h9, 32'hFFFF_FFFF);
    rdc(4'h9, 32'hFFFF_FFFF, 32'h0000_0000);
    // Ratio fields, first pass without fraction
    for (i = 0; i < 3; i = i + 1) begin
      d = $random(seed) & (i == 0 ? 32'hFFF0_FFFF : 32'hFFFF_FFFF);
      wr(`ADDR_RATIO, d);
      rdc(`ADDR_RATIO, 32'hFFFF_FFFF, model_ratio);
      cmp({model_ratio[19:16], model_ratio[11:0]}, {ratio_fraction_o, ratio_integer_o});
      cmp(model_ratio[19:16] != 4'h0, fractional_mode_o);
    end
    // Filter override then automatic, detector bypass on then off
    wr(`ADDR_CTRL_SECOND, 32'h0000_000E);
    rdc(`ADDR_STATUS, 32'h0000_0000, 32'h0000_0000);
    cmp(32'h0000_000D, {filter_override_o, filter_select_o, phase_detector_bypass_o});
    wr(`ADDR_CTRL_SECOND, 32'h0000_0003);
    rdc(`ADDR_STATUS, 32'h0000_0000, 32'h0000_0000);
    cmp(32'h0000_0000, {filter_override_o, filter_select_o, phase_detector_bypass_o});
    // Every reference select code, divider 1 on the fast crystal
    for (i = 0; i < 4; i = i + 1) begin
      wr(`ADDR_CTRL_FIRST, 32'h0000_0000);
      wr(`ADDR_CTRL_SECOND, (i << 5) | 32'h0001_0000);
      wr(`ADDR_CTRL_FIRST, 32'h0000_0002);
      repeat (10) @(posedge clk_sys_i);
      count(i);
      ex = i == 1 ? k / (2 * (1 + 1)) : i == 3 ? 0 : k;
      cmp(r <= ex + 1 && ex <= r + 1, 1);
    end
    // Wake up fast with lock bypass, lock held low
    wr(`ADDR_CTRL_FIRST, 32'h0000_0000);
    wr(`ADDR_CTRL_SECOND, 32'h0000_1010);
    wr(`ADDR_CTRL_FIRST, 32'h0000_0002);
    rdc(`ADDR_STATUS, 32'h0000_0008, 32'h0000_0000);
    repeat (24) @(posedge clk_sys_i);
    rdc(`ADDR_STATUS, 32'h0000_0008, 32'h0000_0008);
    cmp(1, output_clock_gater_o);
    // Normal mode: release on lock, ratio change, lock fail
    wr(`ADDR_CTRL_FIRST, 32'h0000_0000);
    wr(`ADDR_CTRL_SECOND, 32'h0000_0000);
    wr(`ADDR_INT_FLAG, 32'h0000_0007);
    wr(`ADDR_INT_MASK, 32'h0000_0002);
    wr(`ADDR_CTRL_FIRST, 32'h0000_0002);
    repeat (40) @(posedge clk_sys_i);
    rdc(`ADDR_STATUS, 32'h0000_0008, 32'h0000_0000);
    lock_allow <= 1'b1;
    repeat (40) @(posedge clk_sys_i);
    rdc(`ADDR_STATUS, 32'h0000_0009, 32'h0000_0009);
    cmp(1, output_clock_gater_o);
    wr(`ADDR_RATIO, 32'h0000_0005);
    rdc(`ADDR_STATUS, 32'h0000_0001, 32'h0000_0000);
    cmp(0, output_clock_gater_o);
    repeat (80) @(posedge clk_sys_i);
    rdc(`ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    cmp(1, irq_o);
    wr(`ADDR_INT_FLAG, 32'h0000_0005);
    rdc(`ADDR_INT_FLAG, 32'h0000_0002, 32'h0000_0002);
    wr(`ADDR_INT_FLAG, 32'h0000_0002);
    rdc(`ADDR_INT_FLAG, 32'h0000_0002, 32'h0000_0000);
    cmp(0, irq_o);
    lock_allow <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    #1 cmp(2'b01, {output_clock_gater_o, irq_o});
    wr(`ADDR_INT_MASK, 32'h0000_0000);
    rdc(`ADDR_INT_FLAG, 32'h0000_0002, 32'h0000_0002);
    cmp(0, irq_o);
    // Lock timer of two ticks
    wr(`ADDR_CTRL_FIRST, 32'h0000_0000);
    wr(`ADDR_INT_FLAG, 32'h0000_0007);
    wr(`ADDR_CTRL_SECOND, 32'h0000_0200);
    wr(`ADDR_CTRL_FIRST, 32'h0000_0002);
    repeat (40) @(posedge clk_sys_i);
    rdc(`ADDR_STATUS, 32'h0000_0008, 32'h0000_0000);
    repeat (200) @(posedge clk_sys_i);
    rdc(`ADDR_STATUS, 32'h0000_0009, 32'h0000_0009);
    rdc(`ADDR_INT_FLAG, 32'h0000_0004, 32'h0000_0004);
    wr(`ADDR_CTRL_FIRST, 32'h0000_0000);
    repeat (3) @(posedge clk_sys_i);
    #1 cmp(2'b10, {output_clock_reset_o, pll_reference_clock_o});
    close_out;
  end
endmodule
